/* File: logic/pitc_core.sv */
// priority interrupt and trap controller core
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Contract
// [R1] each source has a flag set by its peripheral, cleared only by software
// [R2] each source has a software enable bit gating its own requests
// [R3] each user source has a three-bit priority, one of eight levels
// [R4] pending vector number latched in 7 bits, new level in 4 bits
// [R5] latched new level equals priority of the pending interrupt
// [R6] sources map to flag, enable, priority bits in vector order
// [R7] status word bits 7:5 hold low level bits, software writable
// [R8] top level bit in core control word cannot be set by software
// [R9] level value 111 means 7 and blocks all user interrupts
// [R10] top bit above three bits forms level; top 1 blocks user interrupts
// [R11] while nesting disabled, status level bits ignore software writes
// [R12] control one bit 15 disables nesting, resets to 0
// [R13] accumulator A overflow sets bit 14, B sets bit 13
// [R14] catastrophic overflow A sets bit 12, B sets bit 11
// [R15] overflow traps only when enabled by bits 10, 9 and 8
// [R16] invalid shift math trap sets bit 7
// [R17] divide by zero math trap sets bit 6
// [R18] any math trap sets bit 4
// [R19] address error trap sets bit 3
// [R20] bit 5 of control one always reads zero
// [R21] control two sets pin edge detection and vector table choice
// [R22] control two bit 15 selects the alternate vector table
// [R23] control two bits 2:0 pick falling (1) or rising (0) edge per pin
// [R24] stack error sets bit 2, oscillator failure sets bit 1
// [R25] request presented only if flagged, enabled, priority above level
// [R26] ties in priority go to the lowest vector number
// ----------------------------------------------------------------
module pitc_core
    import pitc_pkg::*;
#(
    parameter int NUM_SRC = 16
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [NUM_SRC-1:0] periph_req,
    input wire logic [EXT_PINS-1:0] ext_pin,
    input wire logic acc_a_ovf,
    input wire logic acc_b_ovf,
    input wire logic acc_a_cat,
    input wire logic acc_b_cat,
    input wire logic bad_shift_evt,
    input wire logic divide_zero_evt,
    input wire logic address_evt,
    input wire logic stack_evt,
    input wire logic osc_fail_evt,
    input wire logic cpu_level_wr,
    input wire logic [3:0] cpu_level_in,
    output logic irq_valid,
    output logic [6:0] pending_vector_number,
    output logic [3:0] new_priority_level,
    output logic trap_req,
    output logic alt_table_select,
    output logic [3:0] cpu_priority_level
);

    // elaboration check: flags and enables are packed into one sixteen-bit word
    if (NUM_SRC < EXT_PINS || NUM_SRC > 16)
    begin : g_bad_src
        $error("pitc_core: NUM_SRC must lie between 3 and 16");
    end

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    wire logic wr_ctrl_one = reg_wr && reg_addr == OFS_CTRL_ONE;
    wire logic wr_ctrl_two = reg_wr && reg_addr == OFS_CTRL_TWO;
    wire logic wr_status = reg_wr && reg_addr == OFS_STATUS_WORD;
    wire logic wr_core = reg_wr && reg_addr == OFS_CORE_CTRL;
    wire logic wr_flag = reg_wr && reg_addr == OFS_FLAG_BASE;
    wire logic wr_enable = reg_wr && reg_addr == OFS_ENABLE_BASE;
    wire logic [7:0] prio_off = reg_addr - OFS_PRIO_BASE;
    wire logic prio_hit = reg_addr >= OFS_PRIO_BASE && prio_off < 8'h10
        && prio_off[1:0] == 2'b00;
    wire logic [1:0] prio_word = prio_off[3:2];

    logic [15:0] ctrl_one_reg;
    logic [15:0] ctrl_two_reg;
    logic [2:0] level_low_reg;
    logic level_top_reg;
    logic [NUM_SRC-1:0] flag_reg;
    logic [NUM_SRC-1:0] enable_reg;
    logic [2:0] prio_reg [NUM_SRC];
    logic [15:0] rdata_reg;
    logic [EXT_PINS-1:0] pin_s1_reg;
    logic [EXT_PINS-1:0] pin_s2_reg;
    logic [EXT_PINS-1:0] pin_s3_reg;
    logic [6:0] vec_reg;
    logic [3:0] pend_level_reg;
    logic valid_reg;

    // ----------------------------------------------------------------
    // external pins: two-stage synchroniser then edge detect
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
        end
        else
        begin
            pin_s1_reg <= ext_pin;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    // [R23] per-pin edge polarity
    wire logic [EXT_PINS-1:0] rise = pin_s2_reg & ~pin_s3_reg;
    wire logic [EXT_PINS-1:0] fall = ~pin_s2_reg & pin_s3_reg;
    wire logic [EXT_PINS-1:0] pin_evt =
        (ctrl_two_reg[EXT_PINS-1:0] & fall) | (~ctrl_two_reg[EXT_PINS-1:0] & rise);

    // [R6] pins occupy the low sources in vector order, pin 0 at bit 0
    wire logic [NUM_SRC-1:0] src_evt =
        periph_req | {{(NUM_SRC-EXT_PINS){1'b0}}, pin_evt};

    // ----------------------------------------------------------------
    // request flags and enables, one generate slice per source
    // ----------------------------------------------------------------
    genvar gi;
    for (gi = 0; gi < NUM_SRC; gi++)
    begin : g_src
        always_ff @(posedge sys_clk)
        begin
            if (sys_rst)
            begin
                flag_reg[gi] <= 1'b0;
                enable_reg[gi] <= 1'b0;
                prio_reg[gi] <= 3'h0;
            end
            else
            begin
                // [R1] set wins over a software clear in the same cycle
                flag_reg[gi] <= src_evt[gi] | (wr_flag ? reg_wdata[gi] : flag_reg[gi]);
                // [R2] software enable per source
                if (wr_enable)
                    enable_reg[gi] <= reg_wdata[gi];
                // [R3] four three-bit fields per priority word
                if (reg_wr && prio_hit && prio_word == 2'(gi / 4))
                    prio_reg[gi] <= reg_wdata[(gi % 4) * 4 +: 3];
            end
        end
    end

    // ----------------------------------------------------------------
    // trap event flags in control one
    // ----------------------------------------------------------------
    // [R15] overflow flags only when their trap enable is set
    wire logic ova_set = acc_a_ovf && ctrl_one_reg[OVA_TE_BIT];
    wire logic ovb_set = acc_b_ovf && ctrl_one_reg[OVB_TE_BIT];
    wire logic cova_set = acc_a_cat && ctrl_one_reg[COV_TE_BIT];
    wire logic covb_set = acc_b_cat && ctrl_one_reg[COV_TE_BIT];
    // [R18] any math cause raises the summary flag
    wire logic math_set = bad_shift_evt || divide_zero_evt;
    logic [15:0] trap_set;
    always_comb
    begin
        trap_set = 16'h0000;
        // [R13] plain overflow causes
        trap_set[OVA_FLAG_BIT] = ova_set;
        trap_set[OVB_FLAG_BIT] = ovb_set;
        // [R14] catastrophic causes
        trap_set[COVA_FLAG_BIT] = cova_set;
        trap_set[COVB_FLAG_BIT] = covb_set;
        // [R16] invalid shift
        trap_set[SHIFT_FLAG_BIT] = bad_shift_evt;
        // [R17] divide by zero
        trap_set[DIV0_FLAG_BIT] = divide_zero_evt;
        trap_set[MATH_FLAG_BIT] = math_set;
        // [R19] address error
        trap_set[ADDR_FLAG_BIT] = address_evt;
        // [R24] stack and oscillator failure
        trap_set[STACK_FLAG_BIT] = stack_evt;
        trap_set[OSC_FLAG_BIT] = osc_fail_evt;
    end

    // [R20] bit 5 and bit 0 never store, so read as zero
    wire logic [15:0] ctrl_one_next =
        ((wr_ctrl_one ? reg_wdata : ctrl_one_reg) | trap_set) & CTRL_ONE_MASK;

    always_ff @(posedge sys_clk)
    begin
        // [R12] nesting disable resets to zero with the rest
        if (sys_rst)
            ctrl_one_reg <= CTRL_ONE_RST;
        else
            ctrl_one_reg <= ctrl_one_next;
    end

    // [R21] [R22] control two: table select and pin edges
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            ctrl_two_reg <= CTRL_TWO_RST;
        else if (wr_ctrl_two)
            ctrl_two_reg <= reg_wdata & CTRL_TWO_MASK;
    end

    // ----------------------------------------------------------------
    // cpu priority level
    // ----------------------------------------------------------------
    wire logic nest_dis = ctrl_one_reg[NEST_DIS_BIT];
    // [R11] status word level bits frozen to software while nesting is disabled
    wire logic sw_level_ok = wr_status && !nest_dis;
    // [R8] software may clear the top bit but never set it
    wire logic top_clear = wr_core && !reg_wdata[LEVEL_TOP_BIT];

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            level_low_reg <= LEVEL_RST;
            level_top_reg <= 1'b0;
        end
        else
        begin
            // core-side level load (vectoring, return) takes precedence
            if (cpu_level_wr)
            begin
                level_low_reg <= cpu_level_in[2:0];
                level_top_reg <= cpu_level_in[3];
            end
            else
            begin
                // [R7] software rewrite of status word level bits
                if (sw_level_ok)
                    level_low_reg <= reg_wdata[LEVEL_LSB +: 3];
                if (top_clear)
                    level_top_reg <= 1'b0;
            end
        end
    end

    // [R10] top bit concatenated above the three status bits
    wire logic [3:0] cur_level = {level_top_reg, level_low_reg};

    // ----------------------------------------------------------------
    // arbitration
    // ----------------------------------------------------------------
    logic [3:0] best_prio;
    logic [6:0] best_vec;
    logic best_hit;
    always_comb
    begin
        best_prio = 4'h0;
        best_vec = 7'h00;
        best_hit = 1'b0;
        // [R26] scan from high index so lower vectors win ties
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            // [R25] flagged, enabled and above current level
            // [R9] no user priority exceeds level 7, so none passes
            if (flag_reg[i] && enable_reg[i] && {1'b0, prio_reg[i]} > cur_level
                && (!best_hit || {1'b0, prio_reg[i]} >= best_prio))
            begin
                best_prio = {1'b0, prio_reg[i]};
                best_vec = USER_VEC_BASE + 7'(i);
                best_hit = 1'b1;
            end
        end
    end

    // [R4] [R5] latch vector number and its priority
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            vec_reg <= 7'h00;
            pend_level_reg <= 4'h0;
            valid_reg <= 1'b0;
        end
        else
        begin
            valid_reg <= best_hit;
            if (best_hit)
            begin
                vec_reg <= best_vec;
                pend_level_reg <= best_prio;
            end
        end
    end

    // ----------------------------------------------------------------
    // read path, data one cycle after the strobe
    // ----------------------------------------------------------------
    logic [15:0] rd_mux;
    always_comb
    begin
        rd_mux = 16'h0000;
        if (reg_addr == OFS_CTRL_ONE)
            rd_mux = ctrl_one_reg;
        else if (reg_addr == OFS_CTRL_TWO)
            rd_mux = ctrl_two_reg;
        else if (reg_addr == OFS_STATUS_WORD)
            rd_mux[LEVEL_LSB +: 3] = level_low_reg;
        else if (reg_addr == OFS_CORE_CTRL)
            rd_mux[LEVEL_TOP_BIT] = level_top_reg;
        else if (reg_addr == OFS_PEND_VEC)
            rd_mux = {4'h0, pend_level_reg, 1'b0, vec_reg};
        else if (reg_addr == OFS_FLAG_BASE)
            rd_mux[NUM_SRC-1:0] = flag_reg;
        else if (reg_addr == OFS_ENABLE_BASE)
            rd_mux[NUM_SRC-1:0] = enable_reg;
        else if (prio_hit)
        begin
            for (int k = 0; k < 4; k++)
            begin
                if (int'(prio_word) * 4 + k < NUM_SRC)
                    rd_mux[k * 4 +: 3] = prio_reg[int'(prio_word) * 4 + k];
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            rdata_reg <= 16'h0000;
        else if (reg_rd)
            rdata_reg <= rd_mux;
        else
            rdata_reg <= 16'h0000;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata = rdata_reg;
    assign irq_valid = valid_reg;
    assign pending_vector_number = vec_reg;
    assign new_priority_level = pend_level_reg;
    // traps cannot be masked by level; any trap cause flag requests
    assign trap_req = |(ctrl_one_reg & ~CTRL_ONE_MASK | ctrl_one_reg & 16'h78de);
    assign alt_table_select = ctrl_two_reg[ALT_TABLE_BIT];
    assign cpu_priority_level = cur_level;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_clear_write(int b);
        wr_flag && !reg_wdata[b];
    endsequence

    a_flag_sticky: assert property (src_evt[0] |=> flag_reg[0]) // [R1]
        else $error("flag lost after source event");
    a_flag_clear: assert property (s_clear_write(0) ##0 !src_evt[0] |=> !flag_reg[0]) // [R1]
        else $error("flag not cleared by write");
    a_level_frozen: assert property (nest_dis && wr_status && !cpu_level_wr // [R11]
        |=> $stable(level_low_reg))
        else $error("level changed while nesting disabled");
    a_top_never_set: assert property (!cpu_level_wr && !level_top_reg // [R8]
        |=> !level_top_reg)
        else $error("software set top level bit");
    a_level_matches: assert property (best_hit // [R5]
        |=> valid_reg && pend_level_reg == $past(best_prio))
        else $error("latched level differs from pending priority");
    a_level_blocks: assert property (cur_level >= 4'h7 |=> !valid_reg) // [R9]
        else $error("request passed at level seven or above");
    a_math_summary: assert property (bad_shift_evt |=> ctrl_one_reg[MATH_FLAG_BIT] // [R18]
        && ctrl_one_reg[SHIFT_FLAG_BIT])
        else $error("math summary flag not set");
    a_ovf_gated: assert property (!ctrl_one_reg[OVA_TE_BIT] && !ctrl_one_reg[OVA_FLAG_BIT] // [R15]
        && !(wr_ctrl_one && reg_wdata[OVA_FLAG_BIT]) |=> !ctrl_one_reg[OVA_FLAG_BIT])
        else $error("overflow flag set while trap disabled");
    a_bit5_zero: assert property (reg_rd && reg_addr == OFS_CTRL_ONE // [R20]
        |=> !reg_rdata[5] && !reg_rdata[0])
        else $error("unimplemented bit read as one");
    a_read_one_cycle: assert property (!reg_rd |=> reg_rdata == 16'h0000) // strobed read port, an implementer's choice
        else $error("read data outside answer cycle");

endmodule

/* File: logic/pitc_pkg.sv */
// constants for the priority interrupt and trap controller
package pitc_pkg;
    // register word offsets (chosen map, byte addresses on the plain port)
    localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
    localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
    localparam logic [7:0] OFS_STATUS_WORD = 8'h08;
    localparam logic [7:0] OFS_CORE_CTRL = 8'h0c;
    localparam logic [7:0] OFS_PEND_VEC = 8'h10;
    localparam logic [7:0] OFS_FLAG_BASE = 8'h20;
    localparam logic [7:0] OFS_ENABLE_BASE = 8'h40;
    localparam logic [7:0] OFS_PRIO_BASE = 8'h60;
    // interrupt_control_one field positions
    localparam int NEST_DIS_BIT = 15;
    localparam int OVA_FLAG_BIT = 14;
    localparam int OVB_FLAG_BIT = 13;
    localparam int COVA_FLAG_BIT = 12;
    localparam int COVB_FLAG_BIT = 11;
    localparam int OVA_TE_BIT = 10;
    localparam int OVB_TE_BIT = 9;
    localparam int COV_TE_BIT = 8;
    localparam int SHIFT_FLAG_BIT = 7;
    localparam int DIV0_FLAG_BIT = 6;
    localparam int MATH_FLAG_BIT = 4;
    localparam int ADDR_FLAG_BIT = 3;
    localparam int STACK_FLAG_BIT = 2;
    localparam int OSC_FLAG_BIT = 1;
    localparam logic [15:0] CTRL_ONE_MASK = 16'hffde;
    // interrupt_control_two fields
    localparam int ALT_TABLE_BIT = 15;
    localparam logic [15:0] CTRL_TWO_MASK = 16'h8007;
    // status word and core control fields
    localparam int LEVEL_LSB = 5;
    localparam int LEVEL_TOP_BIT = 3;
    // reset values
    localparam logic [15:0] CTRL_ONE_RST = 16'h0000;
    localparam logic [15:0] CTRL_TWO_RST = 16'h0000;
    localparam logic [2:0] LEVEL_RST = 3'h0;
    // user vectors start after the eight trap vectors
    localparam logic [6:0] USER_VEC_BASE = 7'h08;
    localparam int EXT_PINS = 3;
endpackage

/* File: bench/pitc_far_model.sv */
// far-side model: peripherals, external pins and cpu core around the controller
`timescale 1ns/1ns
module pitc_far_model
    import pitc_pkg::*;
#(
    parameter int NUM_SRC = 16
)
(
    input wire logic sys_clk,
    output logic [NUM_SRC-1:0] periph_req,
    output logic [EXT_PINS-1:0] ext_pin,
    output logic [8:0] evt,
    output logic cpu_level_wr,
    output logic [3:0] cpu_level_in
);
    // ----------------------------------------------------------------
    // idle levels
    // ----------------------------------------------------------------
    // everything quiet at time zero so reset sees no stray pulse
    initial
    begin
        periph_req = '0;
        ext_pin = '0;
        evt = '0;
        cpu_level_wr = 1'b0;
        cpu_level_in = 4'h0;
    end

    // ----------------------------------------------------------------
    // stimulus tasks
    // ----------------------------------------------------------------
    // one-cycle set pulse from a peripheral
    task automatic pulse_src(input int i);
        @(posedge sys_clk);
        periph_req[i] <= 1'b1;
        @(posedge sys_clk);
        periph_req[i] <= 1'b0;
    endtask

    // one-cycle trap cause pulse, index order as wired in the bench
    task automatic pulse_evt(input int i);
        @(posedge sys_clk);
        evt[i] <= 1'b1;
        @(posedge sys_clk);
        evt[i] <= 1'b0;
    endtask

    // core loads its full level; data inverted afterwards so a stale hold shows
    task automatic load_level(input logic [3:0] lv);
        @(posedge sys_clk);
        cpu_level_wr <= 1'b1;
        cpu_level_in <= lv;
        @(posedge sys_clk);
        cpu_level_wr <= 1'b0;
        cpu_level_in <= ~lv;
    endtask

    // pin level change, asynchronous to the controller by nature
    task automatic set_pin(input int k, input logic v);
        @(posedge sys_clk);
        ext_pin[k] <= v;
    endtask
endmodule

/* File: bench/pitc_core_tb.sv */
// self-checking bench for the priority interrupt and trap controller
`timescale 1ns/1ns
module pitc_core_tb
    import pitc_pkg::*;
;
    localparam int NSRC = 16;
    // cause bits per event: ova, ovb, cova, covb, shift, div0, addr, stack, osc
    localparam logic [15:0] TRAP_BITS [0:8] = '{16'h4000, 16'h2000, 16'h1000, 16'h0800,
        16'h0090, 16'h0050, 16'h0008, 16'h0004, 16'h0002};
    logic sys_clk;
    logic sys_rst;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic [NSRC-1:0] periph_req;
    logic [EXT_PINS-1:0] ext_pin;
    logic [8:0] evt;
    logic cpu_level_wr;
    logic [3:0] cpu_level_in;
    logic irq_valid;
    logic [6:0] pending_vector_number;
    logic [3:0] new_priority_level;
    logic trap_req;
    logic alt_table_select;
    logic [3:0] cpu_priority_level;
    int num_errors;
    int checked;
    int cycle_count;

    // ----------------------------------------------------------------
    // clock, timeout, instances
    // ----------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // the whole run needs about 310 cycles; 6000 means a hang
    always @(posedge sys_clk)
    begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 6000)
        begin
            num_errors++;
            print_verdict();
        end
    end

    pitc_core #(.NUM_SRC(NSRC)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .periph_req(periph_req), .ext_pin(ext_pin),
        .acc_a_ovf(evt[0]), .acc_b_ovf(evt[1]), .acc_a_cat(evt[2]), .acc_b_cat(evt[3]),
        .bad_shift_evt(evt[4]), .divide_zero_evt(evt[5]), .address_evt(evt[6]),
        .stack_evt(evt[7]), .osc_fail_evt(evt[8]), .cpu_level_wr(cpu_level_wr),
        .cpu_level_in(cpu_level_in), .irq_valid(irq_valid),
        .pending_vector_number(pending_vector_number),
        .new_priority_level(new_priority_level), .trap_req(trap_req),
        .alt_table_select(alt_table_select), .cpu_priority_level(cpu_priority_level));

    pitc_far_model #(.NUM_SRC(NSRC)) i_far (.sys_clk(sys_clk), .periph_req(periph_req),
        .ext_pin(ext_pin), .evt(evt), .cpu_level_wr(cpu_level_wr),
        .cpu_level_in(cpu_level_in));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic print_verdict;
        if (num_errors == 0 && checked > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe, sampled just past that edge
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(what, reg_rdata, exp);
    endtask

    // flag then registered request: two edges, one spare
    task automatic settle;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_user;
        rd_chk("ctrl one reset", OFS_CTRL_ONE, CTRL_ONE_RST);
        rd_chk("unmapped", 8'hfc, 16'h0000);
        reg_write(OFS_PRIO_BASE, 16'h0003);
        i_far.pulse_src(0);
        rd_chk("flag set", OFS_FLAG_BASE, 16'h0001);
        settle();
        check("disabled irq", {15'h0, irq_valid}, 16'h0000);
        reg_write(OFS_ENABLE_BASE, 16'h0001);
        settle();
        check("irq", {15'h0, irq_valid}, 16'h0001);
        check("vector", {9'h0, pending_vector_number}, 16'h0008);
        check("new level", {12'h0, new_priority_level}, 16'h0003);
        rd_chk("pending reg", OFS_PEND_VEC, 16'h0308);
        rd_chk("flag kept", OFS_FLAG_BASE, 16'h0001);
        reg_write(OFS_FLAG_BASE, 16'h0000);
        settle();
        check("irq cleared", {15'h0, irq_valid}, 16'h0000);
    endtask

    task automatic t_tie;
        reg_write(OFS_PRIO_BASE, 16'h0550);
        reg_write(OFS_ENABLE_BASE, 16'h0006);
        rd_chk("enables", OFS_ENABLE_BASE, 16'h0006);
        reg_write(OFS_PRIO_BASE + 8'h0c, 16'hffff);
        rd_chk("prio word 3", OFS_PRIO_BASE + 8'h0c, 16'h7777);
        i_far.pulse_src(2);
        i_far.pulse_src(1);
        settle();
        check("tie vector", {9'h0, pending_vector_number}, 16'h0009);
        check("tie level", {12'h0, new_priority_level}, 16'h0005);
        reg_write(OFS_PRIO_BASE, 16'h0750);
        settle();
        check("top vector", {9'h0, pending_vector_number}, 16'h000a);
        check("top level", {12'h0, new_priority_level}, 16'h0007);
        reg_write(OFS_STATUS_WORD, 16'h00c0);
        settle();
        check("cpu level 6", {12'h0, cpu_priority_level}, 16'h0006);
        check("irq above 6", {15'h0, irq_valid}, 16'h0001);
        reg_write(OFS_STATUS_WORD, 16'h00e0);
        settle();
        check("cpu level 7", {12'h0, cpu_priority_level}, 16'h0007);
        check("irq at 7", {15'h0, irq_valid}, 16'h0000);
    endtask

    task automatic t_nest_top;
        reg_write(OFS_STATUS_WORD, 16'h0000);
        reg_write(OFS_CTRL_ONE, 16'h8000);
        rd_chk("nest bit", OFS_CTRL_ONE, 16'h8000);
        reg_write(OFS_STATUS_WORD, 16'h00a0);
        settle();
        check("locked level", {12'h0, cpu_priority_level}, 16'h0000);
        i_far.load_level(4'h8);
        settle();
        check("level 8", {12'h0, cpu_priority_level}, 16'h0008);
        check("irq at 8", {15'h0, irq_valid}, 16'h0000);
        rd_chk("core top", OFS_CORE_CTRL, 16'h0008);
        reg_write(OFS_CORE_CTRL, 16'h0000);
        reg_write(OFS_CTRL_ONE, 16'h0000);
        settle();
        check("irq at 0", {15'h0, irq_valid}, 16'h0001);
        reg_write(OFS_CORE_CTRL, 16'h0008);
        reg_write(OFS_STATUS_WORD, 16'h00a0);
        settle();
        check("no sw top", {12'h0, cpu_priority_level}, 16'h0005);
        rd_chk("status word", OFS_STATUS_WORD, 16'h00a0);
        reg_write(OFS_STATUS_WORD, 16'h0000);
        reg_write(OFS_FLAG_BASE, 16'h0000);
    endtask

    task automatic t_trap;
        i_far.pulse_evt(0);
        rd_chk("trap disabled", OFS_CTRL_ONE, 16'h0000);
        reg_write(OFS_CTRL_ONE, 16'h0700);
        for (int i = 0; i < 9; i++)
        begin
            i_far.pulse_evt(i);
            rd_chk("trap", OFS_CTRL_ONE, 16'h0700 | TRAP_BITS[i]);
            check("trap req", {15'h0, trap_req}, 16'h0001);
            reg_write(OFS_CTRL_ONE, 16'h0700);
        end
        reg_write(OFS_CTRL_ONE, 16'hffff);
        rd_chk("unused bit", OFS_CTRL_ONE, CTRL_ONE_MASK);
        reg_write(OFS_CTRL_ONE, 16'h0000);
        settle();
        check("trap req off", {15'h0, trap_req}, 16'h0000);
    endtask

    // each pin goes 0 to 1 to 0; polarity picks which edge flags it
    task automatic t_pins;
        rd_chk("ctrl two reset", OFS_CTRL_TWO, CTRL_TWO_RST);
        for (int p = 0; p < 2; p++)
        begin
            reg_write(OFS_CTRL_TWO, p[0] ? 16'hffff : 16'h0000);
            rd_chk("ctrl two", OFS_CTRL_TWO, p[0] ? CTRL_TWO_MASK : 16'h0000);
            check("alt table", {15'h0, alt_table_select}, {15'h0, p[0]});
            for (int k = 0; k < EXT_PINS; k++)
            begin
                i_far.set_pin(k, 1'b1);
                repeat (6) @(posedge sys_clk);
                rd_chk("rise flag", OFS_FLAG_BASE, p[0] ? 16'h0000 : 16'h0001 << k);
                reg_write(OFS_FLAG_BASE, 16'h0000);
                i_far.set_pin(k, 1'b0);
                repeat (6) @(posedge sys_clk);
                rd_chk("fall flag", OFS_FLAG_BASE, p[0] ? 16'h0001 << k : 16'h0000);
                reg_write(OFS_FLAG_BASE, 16'h0000);
            end
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        num_errors = 0;
        checked = 0;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_user();
        t_tie();
        t_nest_top();
        t_trap();
        t_pins();
        print_verdict();
    end
endmodule
